// ===== verilog/glue_pkg.sv
/*
 Constants, types and carriers shared by the processor bus glue and its clock divider.
 Assumes one system clock; processor and timer clocks are derived from it by division.
*/
package glue_pkg;

    // ----------------------------------------
    // Clock division
    // ----------------------------------------
    localparam logic [2:0] DIV_SLOW    = 3'h6;
    localparam logic [2:0] DIV_FAST    = 3'h4;
    localparam logic [2:0] PCLK_HIGH   = 3'h2;
    localparam logic [4:0] TIMER_DIV   = 5'h18;
    localparam logic [4:0] TIMER_HIGH  = 5'h0c;

    // ----------------------------------------
    // I/O ports
    // ----------------------------------------
    localparam logic [7:0] NMI_PORT    = 8'ha0;
    localparam int         NMI_EN_BIT  = 7;
    localparam logic [7:0] PPI_PORT_A  = 8'h60;
    localparam logic [7:0] PPI_PORT_B  = 8'h61;
    localparam logic [7:0] PPI_PORT_C  = 8'h62;
    localparam logic [3:0] ROM_HI_ADDR = 4'hf;

    // ----------------------------------------
    // Processor status codes
    // ----------------------------------------
    localparam logic [2:0] ST_INTA     = 3'h0;
    localparam logic [2:0] ST_IO_RD    = 3'h1;
    localparam logic [2:0] ST_IO_WR    = 3'h2;
    localparam logic [2:0] ST_HALT     = 3'h3;
    localparam logic [2:0] ST_CODE     = 3'h4;
    localparam logic [2:0] ST_MEM_RD   = 3'h5;
    localparam logic [2:0] ST_MEM_WR   = 3'h6;
    localparam logic [2:0] ST_PASSIVE  = 3'h7;

    typedef enum logic [2:0] {
        CYC_IDLE = 3'b001,
        CYC_ADDR = 3'b010,
        CYC_DATA = 3'b100
    } cyc_state_t;

    // Bus commands, active high
    typedef struct packed {
        logic io_wr;
        logic io_rd;
        logic mem_wr;
        logic mem_rd;
        logic io_cyc;
    } cmd_t;

    // Interrupt sources, bit 0 highest priority
    typedef struct packed {
        logic parallel;
        logic floppy;
        logic vsync;
        logic serial1;
        logic serial2;
        logic hard_disk;
        logic keyboard;
        logic timer0;
    } irq_src_t;

endpackage : glue_pkg

// ===== verilog/clock_divider.sv
/*
 Processor and timer clock divider with processor clock edge strobes.
 Assumes the system clock is the oscillator source; speed select is sampled at period wrap.
*/
`timescale 1ns/100ps
`default_nettype none
module clock_divider (
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    input  wire logic fast_sel_i,
    output logic      pclk_o,
    output logic      tclk_o,
    output logic      rise_o,
    output logic      fall_o
);
    import glue_pkg::*;

    typedef struct packed {
        logic [2:0] cnt;
        logic [4:0] tcnt;
        logic       fast;
        logic       pclk;
        logic       tclk;
    } div_state_t;

    div_state_t q;
    div_state_t n;
    logic [2:0] last;

    // ----------------------------------------
    // Dividers
    // ----------------------------------------
    always_comb begin
        n = q;
        last = (q.fast ? DIV_FAST : DIV_SLOW) - 3'h1;
        rise_o = (q.cnt == last);
        fall_o = (q.cnt == PCLK_HIGH - 3'h1);
        if (rise_o) begin
            n.cnt = 3'h0;
            // Speed changes only at a period boundary to avoid runt pulses
            n.fast = fast_sel_i;
        end else begin
            n.cnt = q.cnt + 3'h1;
        end
        n.pclk = (n.cnt < PCLK_HIGH);
        n.tcnt = (q.tcnt == TIMER_DIV - 5'h1) ? 5'h0 : q.tcnt + 5'h1;
        n.tclk = (n.tcnt < TIMER_HIGH);
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            q      <= '0;
            q.pclk <= 1'b1;
            q.tclk <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign pclk_o = q.pclk;
    assign tclk_o = q.tclk;

endmodule : clock_divider
`default_nettype wire

// ===== verilog/cpu_bus_glue_logic.sv
/*
 Glue between an 8-bit multiplexed processor bus and the system bus.
 Assumes all inputs synchronous to sys_clk_i; data transceivers and buffers are external.
*/
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_glue_logic (
    input  wire logic              sys_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              fast_clock_sel_i,
    input  wire logic [2:0]        processor_status_bits_i,
    input  wire logic              int_ctrl_select_n_i,
    input  wire logic [7:0]        ad_i,
    input  wire logic [19:8]       upper_addr_i,
    input  wire logic              wait_request_n_i,
    input  wire logic              power_on_reset_n_i,
    input  wire logic              refresh_n_i,
    input  wire logic              fdc_ack_n_i,
    input  wire logic              onboard_select_n_i,
    input  wire logic              bus_nmi_i,
    input  wire glue_pkg::irq_src_t irq_sources_i,
    input  wire logic [7:0]        keyboard_data_i,
    input  wire logic [3:0]        port_c_inputs_i,
    output logic                   processor_clock_o,
    output logic                   timer_base_clock_o,
    output logic [19:0]            addr_o,
    output logic [7:0]             ad_o,
    output logic                   ad_oe_o,
    output logic                   txcvr_enable_o,
    output logic                   txcvr_to_cpu_o,
    output logic                   ale_o,
    output logic                   data_buffer_enable_n_o,
    output glue_pkg::cmd_t         cmd_o,
    output logic                   halt_o,
    output logic                   reset_o,
    output logic                   buffered_bus_reset_o,
    output logic                   reset_n_o,
    output logic                   processor_ready_o,
    output logic                   nmi_o,
    output logic                   io_mem_o,
    output logic                   rom_select_o,
    output logic                   bus_refresh_n_o,
    output logic                   buffer_dir_o,
    output logic                   buffer_enable_o,
    output logic [7:0]             irq_o,
    output logic [7:0]             port_b_o,
    output logic [3:0]             port_c_outputs_o
);
    import glue_pkg::*;

    typedef struct packed {
        cyc_state_t  cyc;
        logic [7:0]  addr_lo;
        logic [3:0]  addr_mid;
        logic [3:0]  addr_buf;
        logic [3:0]  addr_hi;
        logic        ale;
        cmd_t        cmd;
        logic        inta;
        logic        halt;
        logic        txcvr_en;
        logic        txcvr_rd;
        logic        buf_gate_n;
        logic [7:0]  rd_data;
        logic        rd_oe;
        logic [1:0]  por_sync;
        logic        rst;
        logic        rst_n;
        logic        rst_bus;
        logic        rdy_seen;
        logic        ready;
        logic        nmi_en;
        logic        nmi;
        logic        io_mem;
        logic        rom_sel;
        logic        rfsh_n;
        logic        buf_dir;
        logic        buf_en;
        logic [7:0]  irq;
        logic [7:0]  ppi_b;
        logic [3:0]  ppi_c_lo;
    } state_t;

    state_t q;
    state_t n;

    logic div_rise;
    logic div_fall;
    logic io_cycle;
    logic mem_read;
    logic io_read;
    logic floppy_ack;
    logic refresh_on;
    logic onboard;
    logic data_phase;

    // ----------------------------------------
    // Clock generation
    // ----------------------------------------
    clock_divider u_div (
        .sys_clk_i  (sys_clk_i),
        .rst_n_i    (rst_n_i),
        .fast_sel_i (fast_clock_sel_i),
        .pclk_o     (processor_clock_o),
        .tclk_o     (timer_base_clock_o),
        .rise_o     (div_rise),
        .fall_o     (div_fall)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        n = q;

        // Latch is transparent while the strobe is high
        if (q.ale) begin
            n.addr_lo  = ad_i;
            n.addr_mid = upper_addr_i[11:8];
            n.addr_hi  = upper_addr_i[19:16];
        end
        n.addr_buf = upper_addr_i[15:12];

        // Cycle sequencing on processor clock rising edges
        if (div_rise) begin
            case (q.cyc)
                CYC_IDLE: begin
                    if (processor_status_bits_i != ST_PASSIVE) begin
                        n.cyc = CYC_ADDR;
                        n.ale = 1'b1;
                    end
                end
                CYC_ADDR: begin
                    n.cyc         = CYC_DATA;
                    n.ale         = 1'b0;
                    // Status is still valid here, later it goes passive
                    n.cmd.io_rd   = (processor_status_bits_i == ST_IO_RD);
                    n.cmd.io_wr   = (processor_status_bits_i == ST_IO_WR);
                    n.cmd.mem_rd  = (processor_status_bits_i == ST_MEM_RD) ||
                                    (processor_status_bits_i == ST_CODE);
                    n.cmd.mem_wr  = (processor_status_bits_i == ST_MEM_WR);
                    n.cmd.io_cyc  = !processor_status_bits_i[2];
                    n.inta        = (processor_status_bits_i == ST_INTA);
                    n.halt        = (processor_status_bits_i == ST_HALT);
                end
                CYC_DATA: begin
                    if (processor_status_bits_i == ST_PASSIVE) begin
                        n.cyc  = CYC_IDLE;
                        n.cmd  = '0;
                        n.inta = 1'b0;
                        n.halt = 1'b0;
                    end
                end
                default: begin
                    n.cyc = CYC_IDLE;
                end
            endcase
        end

        data_phase = (n.cyc == CYC_DATA);
        n.txcvr_en = data_phase && !n.inta;
        n.txcvr_rd = n.cmd.io_rd || n.cmd.mem_rd || n.inta;
        // Interrupt controller sits on the unbuffered side
        n.buf_gate_n = !(data_phase && int_ctrl_select_n_i);

        // Register writes
        if (q.cyc == CYC_DATA && q.cmd.io_wr) begin
            case (q.addr_lo)
                NMI_PORT:   n.nmi_en   = ad_i[NMI_EN_BIT];
                PPI_PORT_B: n.ppi_b    = ad_i;
                PPI_PORT_C: n.ppi_c_lo = ad_i[3:0];
                default:    n.nmi_en   = q.nmi_en;
            endcase
        end

        // Register reads; the enable port reads nothing back
        n.rd_oe = 1'b0;
        if (data_phase && n.cmd.io_rd) begin
            case (n.addr_lo)
                PPI_PORT_A: begin
                    n.rd_data = keyboard_data_i;
                    n.rd_oe   = 1'b1;
                end
                PPI_PORT_B: begin
                    n.rd_data = q.ppi_b;
                    n.rd_oe   = 1'b1;
                end
                PPI_PORT_C: begin
                    n.rd_data = {port_c_inputs_i, q.ppi_c_lo};
                    n.rd_oe   = 1'b1;
                end
                default: begin
                    n.rd_data = q.rd_data;
                end
            endcase
        end

        // Reset chain on processor clock edges
        if (div_rise) begin
            n.por_sync = {q.por_sync[0], !power_on_reset_n_i};
            n.rst      = q.por_sync[1];
            n.rst_n    = !q.por_sync[1];
        end
        if (div_fall) begin
            n.rst_bus = q.rst;
        end

        // Ready: drop on a rising edge, return after rise then fall
        if (div_rise) begin
            n.rdy_seen = wait_request_n_i;
            if (!wait_request_n_i) begin
                n.ready = 1'b0;
            end
        end
        if (div_fall && q.rdy_seen && wait_request_n_i) begin
            n.ready = 1'b1;
        end

        // Buffer control terms
        io_cycle   = q.cmd.io_cyc;
        mem_read   = q.cmd.mem_rd;
        io_read    = q.cmd.io_rd;
        floppy_ack = !fdc_ack_n_i;
        refresh_on = !refresh_n_i;
        onboard    = !onboard_select_n_i;
        n.rom_sel  = mem_read && !refresh_on && (q.addr_hi == ROM_HI_ADDR);
        n.rfsh_n   = refresh_n_i;
        n.buf_dir  = !((mem_read && !io_cycle && !floppy_ack) ||
                       (mem_read && !io_cycle && onboard) ||
                       (mem_read && !io_cycle && io_read) ||
                       (io_read && io_cycle) ||
                       (io_read && floppy_ack && !onboard && !mem_read));
        n.buf_en   = !((!onboard && !q.rom_sel && !floppy_ack) ||
                       (onboard && floppy_ack));
        n.io_mem   = !io_cycle;
        n.nmi    = q.nmi_en && bus_nmi_i;
        n.irq    = irq_sources_i;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            q         <= '0;
            q.cyc     <= CYC_IDLE;
            q.buf_gate_n <= 1'b1;
            q.por_sync <= 2'h3;
            q.rst     <= 1'b1;
            q.rst_bus <= 1'b1;
            q.rfsh_n  <= 1'b1;
            q.buf_dir <= 1'b1;
            q.io_mem  <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign addr_o                 = {q.addr_hi, q.addr_buf, q.addr_mid, q.addr_lo};
    assign ad_o                   = q.rd_data;
    assign ad_oe_o                = q.rd_oe;
    assign txcvr_enable_o         = q.txcvr_en;
    assign txcvr_to_cpu_o         = q.txcvr_rd;
    assign ale_o                  = q.ale;
    assign data_buffer_enable_n_o = q.buf_gate_n;
    assign cmd_o                  = q.cmd;
    assign halt_o                 = q.halt;
    assign reset_o                = q.rst;
    assign buffered_bus_reset_o   = q.rst_bus;
    assign reset_n_o              = q.rst_n;
    assign processor_ready_o      = q.ready;
    assign nmi_o                  = q.nmi;
    assign io_mem_o               = q.io_mem;
    assign rom_select_o           = q.rom_sel;
    assign bus_refresh_n_o        = q.rfsh_n;
    assign buffer_dir_o           = q.buf_dir;
    assign buffer_enable_o        = q.buf_en;
    assign irq_o                  = q.irq;
    assign port_b_o               = q.ppi_b;
    assign port_c_outputs_o       = q.ppi_c_lo;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence cyc_start_s;
        q.cyc == CYC_IDLE && div_rise && processor_status_bits_i != ST_PASSIVE;
    endsequence

    sequence ale_pulse_s;
        ale_o && !txcvr_enable_o;
    endsequence

    property cycle_opens_p;
        cyc_start_s |=> ale_pulse_s;
    endproperty

    clock_high_a: assert property ($rose(processor_clock_o) |-> ##1 processor_clock_o ##1 !processor_clock_o)
        else $error("processor clock high time wrong");
    timer_half_a: assert property ($rose(timer_base_clock_o) |-> ##11 timer_base_clock_o ##1 !timer_base_clock_o)
        else $error("timer clock half period wrong");
    ale_open_a: assert property (cycle_opens_p)
        else $error("address strobe missing at cycle start");
    addr_hold_a: assert property ($fell(ale_o) |=> $stable(addr_o[7:0]))
        else $error("low address moved after strobe");
    inta_txcvr_a: assert property (q.inta |-> !txcvr_enable_o)
        else $error("transceiver enabled in acknowledge");
    buf_gate_a: assert property (!data_buffer_enable_n_o |-> $past(int_ctrl_select_n_i))
        else $error("data buffer enabled on controller access");
    ready_drop_a: assert property (div_rise && !wait_request_n_i |=> !processor_ready_o)
        else $error("ready not dropped on wait request");
    ready_return_a: assert property ($rose(processor_ready_o) |-> $past(div_fall) && $past(q.rdy_seen))
        else $error("ready returned without rise then fall");
    bus_reset_edge_a: assert property ($changed(buffered_bus_reset_o) |-> $past(div_fall))
        else $error("bus reset moved off falling edge");
    nmi_gate_a: assert property (nmi_o |-> $past(q.nmi_en) && $past(bus_nmi_i))
        else $error("nmi passed while disabled");
    nmi_reset_a: assert property (disable iff (1'b0) !rst_n_i |=> !q.nmi_en)
        else $error("nmi enable survived reset");

    // Glue terms lag their inputs by one cycle
    rom_decode_a: assert property (rom_select_o |-> $past(cmd_o.mem_rd) && $past(refresh_n_i) && $past(addr_o[19:16]) == ROM_HI_ADDR)
        else $error("rom select without memory read of top block");
    refresh_copy_a: assert property ($past(rst_n_i) |-> bus_refresh_n_o == $past(refresh_n_i))
        else $error("bus refresh does not follow its input");
    dir_io_read_a: assert property (cmd_o.io_rd && cmd_o.io_cyc |=> !buffer_dir_o)
        else $error("buffer direction not turned for io read");
    dir_write_a: assert property (!cmd_o.mem_rd && !cmd_o.io_rd |=> buffer_dir_o)
        else $error("buffer direction turned without a read");
    enable_none_a: assert property (onboard_select_n_i && !rom_select_o && fdc_ack_n_i |=> !buffer_enable_o)
        else $error("buffer enabled with no select");
    enable_both_a: assert property (!onboard_select_n_i && !fdc_ack_n_i |=> !buffer_enable_o)
        else $error("buffer enabled with onboard and floppy");
    io_mem_inv_a: assert property ($past(rst_n_i) |-> io_mem_o == !$past(cmd_o.io_cyc))
        else $error("io memory output not inverted");
    irq_map_a: assert property ($past(rst_n_i) |-> irq_o == $past(irq_sources_i))
        else $error("interrupt lines out of order");
    reset_pair_a: assert property (reset_n_o == !reset_o)
        else $error("reset outputs disagree");
    txcvr_dir_a: assert property (txcvr_enable_o && (cmd_o.io_rd || cmd_o.mem_rd) |-> txcvr_to_cpu_o)
        else $error("transceiver not toward processor on read");

endmodule : cpu_bus_glue_logic
`default_nettype wire

// ===== tb/wait_peripheral.sv
/*
 Wait-state peripheral on the system bus side of the glue.
 Assumes active high commands and a pull-up on the wait line.
*/
`timescale 1ns/100ps
`default_nettype none
module wait_peripheral (
    input  wire logic           sys_clk_i,
    input  wire glue_pkg::cmd_t cmd_i,
    input  wire logic [3:0]     hold_len_i,
    output logic                wait_request_n_o
);
    import glue_pkg::*;
    // --------------------------------
    // Wait generation
    // --------------------------------
    logic [3:0] left_q = 4'h0;
    logic       busy_q = 1'b0;
    // Pull low at once on a new command; capped, a longer hold would hang the bus
    always @(posedge sys_clk_i) begin
        busy_q <= |cmd_i[4:1];
        if ((|cmd_i[4:1]) && !busy_q) begin
            left_q <= (hold_len_i > 4'ha) ? 4'ha : hold_len_i;
        end else if (left_q != 4'h0) begin
            left_q <= left_q - 4'h1;
        end
    end
    // Released line rises to the pull-up level
    assign wait_request_n_o = (left_q == 4'h0);
endmodule : wait_peripheral
`default_nettype wire

// ===== tb/testbench.sv
/*
 Self-checking bench for the processor bus glue.
 Assumes the glue package and the wait peripheral model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import glue_pkg::*;
    // --------------------------------
    // Signals
    // --------------------------------
    logic        sys_clk_i = 1'b0, rst_n_i = 1'b0, fast_clock_sel_i = 1'b0, int_ctrl_select_n_i = 1'b1;
    logic [2:0]  processor_status_bits_i = ST_PASSIVE;
    logic [7:0]  ad_i = 8'h00, keyboard_data_i = 8'h00, ad_o, irq_o, port_b_o;
    logic [19:8] upper_addr_i = 12'h000;
    logic        wait_request_n_i, power_on_reset_n_i = 1'b0, refresh_n_i = 1'b1, fdc_ack_n_i = 1'b1;
    logic        onboard_select_n_i = 1'b1, bus_nmi_i = 1'b0;
    irq_src_t    irq_sources_i = 8'h00;
    logic [3:0]  port_c_inputs_i = 4'h0, port_c_outputs_o, hold_len = 4'h0;
    logic [19:0] addr_o;
    cmd_t        cmd_o;
    logic        processor_clock_o, timer_base_clock_o, ad_oe_o, txcvr_enable_o, txcvr_to_cpu_o, ale_o;
    logic        data_buffer_enable_n_o, halt_o, reset_o, buffered_bus_reset_o, reset_n_o, processor_ready_o;
    logic        nmi_o, io_mem_o, rom_select_o, bus_refresh_n_o, buffer_dir_o, buffer_enable_o;
    int          err_total = 0, total_checks = 0, rel;
    logic [2:0]  sts [5] = '{ST_IO_RD, ST_IO_WR, ST_MEM_RD, ST_MEM_WR, ST_CODE};
    logic [9:0]  exp [5] = '{10'h130, 10'h228, 10'h057, 10'h08c, 10'h057};

    cpu_bus_glue_logic cpu_bus_glue_logic_inst (
        .sys_clk_i, .rst_n_i, .fast_clock_sel_i, .processor_status_bits_i, .int_ctrl_select_n_i, .ad_i,
        .upper_addr_i, .wait_request_n_i, .power_on_reset_n_i, .refresh_n_i, .fdc_ack_n_i,
        .onboard_select_n_i, .bus_nmi_i, .irq_sources_i, .keyboard_data_i, .port_c_inputs_i,
        .processor_clock_o, .timer_base_clock_o, .addr_o, .ad_o, .ad_oe_o, .txcvr_enable_o,
        .txcvr_to_cpu_o, .ale_o, .data_buffer_enable_n_o, .cmd_o, .halt_o, .reset_o, .buffered_bus_reset_o,
        .reset_n_o, .processor_ready_o, .nmi_o, .io_mem_o, .rom_select_o, .bus_refresh_n_o,
        .buffer_dir_o, .buffer_enable_o, .irq_o, .port_b_o, .port_c_outputs_o
    );
    wait_peripheral wait_peripheral_inst (
        .sys_clk_i(sys_clk_i), .cmd_i(cmd_o), .hold_len_i(hold_len), .wait_request_n_o(wait_request_n_i)
    );

    always #12.5 sys_clk_i = ~sys_clk_i;

    task automatic chk(input string n, input logic [19:0] e, input logic [19:0] s);
        total_checks++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask : cyc

    // Address phase, then data phase held until ready; rel counts released-but-not-ready cycles
    task automatic bus_begin(input logic [2:0] s, input logic [19:0] a, input logic [7:0] d);
        int i;
        processor_status_bits_i = s;
        ad_i = a[7:0];
        upper_addr_i = a[19:8];
        for (i = 0; i < 40 && ale_o !== 1'b1; i++) cyc(1);
        for (i = 0; i < 40 && ale_o === 1'b1; i++) cyc(1);
        ad_i = d;
        upper_addr_i = ~a[19:8];
        if (hold_len != 4'h0) for (i = 0; i < 20 && processor_ready_o === 1'b1; i++) cyc(1);
        rel = 0;
        for (i = 0; i < 80 && processor_ready_o !== 1'b1; i++) begin
            cyc(1);
            rel += int'(wait_request_n_i === 1'b1);
        end
        cyc(3);
    endtask : bus_begin

    task automatic bus_end();
        int i;
        processor_status_bits_i = ST_PASSIVE;
        for (i = 0; i < 40 && (cmd_o !== 5'h00 || txcvr_enable_o !== 1'b0); i++) cyc(1);
        cyc(8);
    endtask : bus_end

    task automatic meas(input logic f, input int rp, input int hp);
        int r = 0, h = 0, t = 0, th = 0;
        logic pv, tv;
        fast_clock_sel_i = f;
        cyc(30);
        pv = processor_clock_o;
        tv = timer_base_clock_o;
        repeat (48) begin
            cyc(1);
            r += int'(!pv && processor_clock_o);
            h += int'(processor_clock_o);
            t += int'(!tv && timer_base_clock_o);
            th += int'(timer_base_clock_o);
            pv = processor_clock_o;
            tv = timer_base_clock_o;
        end
        chk("pclk rises", rp, r);
        chk("pclk high", hp, h);
        chk("tclk rises", 2, t);
        chk("tclk high", 24, th);
    endtask : meas

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude

    // --------------------------------
    // Tests
    // --------------------------------
    initial begin
        int i;
        cyc(11);
        chk("reset outs", 5'b11001, {reset_o, buffered_bus_reset_o, reset_n_o, processor_ready_o,
            data_buffer_enable_n_o});
        cyc(1);
        rst_n_i = 1'b1;
        cyc(20);
        power_on_reset_n_i = 1'b1;
        for (i = 0; i < 40 && reset_o === 1'b1; i++) cyc(1);
        chk("por sync", 1, i >= 7 && i <= 20);
        chk("reset n", 2'b01, {reset_o, reset_n_o});
        for (i = 0; i < 20 && buffered_bus_reset_o !== 1'b0; i++) cyc(1);
        chk("bus rst edge", 0, processor_clock_o);
        meas(1'b0, 8, 16);
        meas(1'b1, 12, 24);
        fast_clock_sel_i = 1'b0;
        cyc(30);
        bus_nmi_i = 1'b1;
        cyc(3);
        chk("nmi off", 0, nmi_o);
        bus_begin(ST_IO_WR, {12'h000, NMI_PORT}, 8'h80);
        bus_end();
        chk("nmi on", 1, nmi_o);
        bus_begin(ST_IO_WR, {12'h000, NMI_PORT}, 8'h7f);
        bus_end();
        chk("nmi bit7", 0, nmi_o);
        bus_begin(ST_IO_WR, {12'h000, PPI_PORT_B}, 8'ha5);
        bus_end();
        chk("port b", 8'ha5, port_b_o);
        bus_begin(ST_IO_WR, {12'h000, PPI_PORT_C}, 8'h3c);
        bus_end();
        chk("port c out", 4'hc, port_c_outputs_o);
        keyboard_data_i = 8'h5a;
        port_c_inputs_i = 4'h9;
        bus_begin(ST_IO_RD, {12'h000, PPI_PORT_A}, 8'h00);
        chk("port a", 9'h15a, {ad_oe_o, ad_o});
        bus_end();
        bus_begin(ST_IO_RD, {12'h000, PPI_PORT_C}, 8'h00);
        chk("port c in", 5'h19, {ad_oe_o, ad_o[7:4]});
        bus_end();
        for (i = 0; i < 5; i++) begin
            bus_begin(sts[i], 20'hf1234, 8'h00);
            chk("cmd", exp[i][9:5], cmd_o);
            chk("to cpu", exp[i][4], txcvr_to_cpu_o);
            chk("buf dir", exp[i][3], buffer_dir_o);
            chk("io mem", exp[i][2], io_mem_o);
            chk("rom sel", exp[i][1], rom_select_o);
            chk("buf en", exp[i][0], buffer_enable_o);
            chk("xcvr on", 2'b10, {txcvr_enable_o, data_buffer_enable_n_o});
            chk("addr", 20'hfe234, addr_o);
            bus_end();
        end
        bus_begin(ST_INTA, 20'h00000, 8'h00);
        chk("inta xcvr", 0, txcvr_enable_o);
        bus_end();
        bus_begin(ST_HALT, 20'h00000, 8'h00);
        chk("halt", 1, halt_o);
        bus_end();
        int_ctrl_select_n_i = 1'b0;
        bus_begin(ST_IO_RD, 20'h00020, 8'h00);
        chk("ctrl den", 1, data_buffer_enable_n_o);
        bus_end();
        int_ctrl_select_n_i = 1'b1;
        hold_len = 4'ha;
        bus_begin(ST_MEM_RD, 20'h01000, 8'h00);
        chk("ready gap", 1, rel >= 2 && rel <= 10);
        chk("ready back", 1, processor_ready_o);
        bus_end();
        hold_len = 4'h0;
        onboard_select_n_i = 1'b0;
        cyc(3);
        chk("en onboard", 1, buffer_enable_o);
        fdc_ack_n_i = 1'b0;
        refresh_n_i = 1'b0;
        cyc(3);
        chk("en both", 0, buffer_enable_o);
        chk("refresh", 0, bus_refresh_n_o);
        for (i = 0; i < 8; i++) begin
            irq_sources_i = irq_src_t'(8'h01 << i);
            cyc(3);
            chk("irq map", 8'h01 << i, irq_o);
        end
        conclude();
    end

    // Whole run is under a thousand cycles
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        err_total++;
        conclude();
    end
endmodule : testbench
`default_nettype wire
